// ---- design/aoc_pkg.sv ----
/*
 * package of the alarm output conditioner: widths, defaults, type codes,
 * timing counts and the configuration structs taken by aoc_top.
 * assumes a single 200 MHz clock and a synchronous active-high reset.
 */
package aoc_pkg;

    // =====================================================================
    // timing
    // =====================================================================
    localparam int unsigned CLK_HZ       = 200_000_000;  // system clock rate
    localparam int unsigned TICK_S       = 1;            // seconds per tick
    localparam int unsigned TICK_CYCLES  = CLK_HZ * TICK_S;
    localparam int          TICK_W       = 28;

    // =====================================================================
    // widths and ranges
    // =====================================================================
    localparam int          DLY_W        = 10;           // 0 to 999 s
    localparam int          LBA_T_W      = 14;           // 0 to 9999 s
    localparam int          AMP_W        = 10;           // current, 0.1 A units
    localparam int          DEV_W        = 16;           // deviation, signed
    localparam int          TYPE_W       = 5;            // alarm type code

    // =====================================================================
    // codes and reset values
    // =====================================================================
    localparam logic [TYPE_W-1:0]  TYPE_NONE    = 5'h00;
    localparam logic [TYPE_W-1:0]  TYPE_LBA     = 5'h0c;  // 12
    localparam logic [TYPE_W-1:0]  TYPE_PV_ABS  = 5'h0d;  // 13
    localparam logic [AMP_W-1:0]   HS_TRIP_OFF  = 10'h1f4; // 50.0 A
    localparam logic [AMP_W-1:0]   HS_HYST_DEF  = 10'h001; // 0.1 A
    localparam logic [DEV_W-1:0]   LBA_LVL_TEMP = 16'h0050; // 8.0, 0.1 units
    localparam logic [DEV_W-1:0]   LBA_LVL_ANA  = 16'h03e8; // 10.00, 0.01 units
    localparam logic [DEV_W-1:0]   LBA_LVL_TMAX = 16'h7e90; // 3240.0
    localparam logic               HS_USE_DEF   = 1'b1;
    localparam logic               HS_LATCH_DEF = 1'b0;

    // per-alarm settings
    typedef struct packed {
        logic              assigned;
        logic [TYPE_W-1:0] kind;
        logic [DLY_W-1:0]  on_dly;
        logic [DLY_W-1:0]  off_dly;
    } aoc_alarm_cfg_t;

    // heater-short settings
    typedef struct packed {
        logic             use_flag;
        logic             latch_flag;
        logic [AMP_W-1:0] trip;
        logic [AMP_W-1:0] hyst;
    } aoc_hs_cfg_t;

    // loop break settings
    typedef struct packed {
        logic [LBA_T_W-1:0] adv_interval;
        logic [LBA_T_W-1:0] pid_interval;
        logic               pid_all_nonzero;
        logic               onoff_ctrl;
        logic [DEV_W-1:0]   level;
        logic [DEV_W-1:0]   band;
    } aoc_lba_cfg_t;

endpackage : aoc_pkg

// ---- design/aoc_delay.sv ----
/*
 * on/off delay stage for one alarm output, counting whole-second ticks.
 * assumes tick is a one-cycle pulse from the same clock domain.
 */
`timescale 1ns/1ps
module aoc_delay
    import aoc_pkg::*;
(
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             tick,
    input  wire logic             dly_en,
    input  wire logic             cond,
    input  wire logic [DLY_W-1:0] on_dly,
    input  wire logic [DLY_W-1:0] off_dly,
    output logic                  out_q
);

    logic [DLY_W-1:0] cnt_q;
    logic [DLY_W-1:0] dly;

    // delay that applies to the pending change
    assign dly = cond ? on_dly : off_dly;

    // =====================================================================
    // delay counter and output
    // =====================================================================
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            out_q <= 1'b0;
            cnt_q <= '0;
        end
        else if (!dly_en || dly == '0)
        begin
            out_q <= cond;
            cnt_q <= '0;
        end
        else if (cond == out_q)
        begin
            cnt_q <= '0;
        end
        else if (tick)
        begin
            if (cnt_q + 10'h001 >= dly)
            begin
                out_q <= cond;
                cnt_q <= '0;
            end
            else
            begin
                cnt_q <= cnt_q + 10'h001;
            end
        end
    end

    // =====================================================================
    // checks
    // =====================================================================
    sequence s_rise;
        !$past(out_q) ##0 out_q;
    endsequence

    AST_ON_HELD: assert property (@(posedge clk) disable iff (rst)
        (s_rise ##0 ($past(dly_en) && $past(on_dly) != '0)) |-> $past(tick))
        else $error("alarm rose without a tick while on delay was set");

    AST_ZERO_ON: assert property (@(posedge clk) disable iff (rst)
        (dly_en && cond && on_dly == '0) |=> out_q)
        else $error("zero on delay did not pass condition");

    AST_OFF_HELD: assert property (@(posedge clk) disable iff (rst)
        ($fell(out_q) && $past(dly_en) && $past(off_dly) != '0) |-> $past(tick))
        else $error("alarm fell without a tick while off delay was set");

    AST_ZERO_OFF: assert property (@(posedge clk) disable iff (rst)
        (dly_en && !cond && off_dly == '0) |=> !out_q)
        else $error("zero off delay did not release");

    AST_NO_DLY: assert property (@(posedge clk) disable iff (rst)
        !dly_en |=> out_q == $past(cond))
        else $error("undelayed alarm did not follow its condition");

    AST_CANCEL: assert property (@(posedge clk) disable iff (rst)
        (dly_en && cond == out_q) |=> cnt_q == '0)
        else $error("pending delay not cleared");

endmodule : aoc_delay

// ---- design/aoc_top.sv ----
/*
 * alarm output conditioner: on/off delays for alarms 1 to 3, heater-short
 * alarm with latch and hysteresis, loop break detection, alarm 1 merging.
 * assumes settings and measurements come from logic on clk; the cancel key
 * and cancel event pins are asynchronous and are synchronised here.
 */
// Operation
// - alarms 1-3 do not turn on before their on delay elapses
// - an on delay of zero turns the alarm on at once
// - alarms 1-3 do not turn off before their off delay elapses
// - an off delay of zero releases the alarm at once
// - delays act only if alarm assigned and type not 0, 12 or 13
// - the use flag gates heater-short evaluation and its alarm 1 drive
// - latched heater short holds until 50.0 A trip, power-up or cancel
// - latched heater short is forced off in the setting levels
// - heater-short release uses a hysteresis band, default 0.1 A
// - hysteresis acts only when enabled and the latch is off
// - loop break interval 0 to 9999 s, zero disables detection
// - loop break works only with alarm 1 assigned and type 12
// - on/off control uses the advanced-level loop break interval
// - loop break needs deviation above the programmed level
// - loop break when deviation over band is not reduced in interval
// - level and band act only with nonzero intervals, all PID sets
// - alarm 1 output ORs alarm 1, heater short, overcurrent, input error
`timescale 1ns/1ps
module aoc_top
    import aoc_pkg::*;
#(
    parameter int unsigned TICK_DIV = TICK_CYCLES  // cycles per second tick
)
(
    input  wire logic                 clk,
    input  wire logic                 rst,
    input  wire aoc_alarm_cfg_t [2:0] alarm_cfg,
    input  wire logic [2:0]           alarm_cond,
    input  wire aoc_hs_cfg_t          hs_cfg,
    input  wire logic [AMP_W-1:0]     heater_current,
    input  wire logic                 overcurrent_alarm,
    input  wire logic                 input_error,
    input  wire logic                 setting_level,
    input  wire logic                 latch_cancel_key_pin,
    input  wire logic                 latch_cancel_event_pin,
    input  wire aoc_lba_cfg_t         lba_cfg,
    input  wire logic [DEV_W-1:0]     deviation,
    output logic                      alarm_one_out_q,
    output logic                      alarm_two_out_q,
    output logic                      alarm_three_out_q,
    output logic                      heater_short_q,
    output logic                      loop_break_alarm_q
);

    // =====================================================================
    // helpers
    // =====================================================================
    // delay applies for this alarm setting
    function automatic logic dly_ok(input aoc_alarm_cfg_t c);
        dly_ok = c.assigned && c.kind != TYPE_NONE && c.kind != TYPE_LBA
                 && c.kind != TYPE_PV_ABS;
    endfunction : dly_ok

    // magnitude of a signed deviation
    function automatic logic [DEV_W-1:0] mag(input logic [DEV_W-1:0] v);
        mag = v[DEV_W-1] ? DEV_W'(~v + 16'h0001) : v;
    endfunction : mag

    // =====================================================================
    // one-second tick divider
    // =====================================================================
    localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_DIV - 1);

    // count and one-cycle pulse
    // TICK_DIV of 1 holds tick high
    logic [TICK_W-1:0] div_q;
    logic              tick_q;

    // tick is a one-cycle enable pulse every second
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            div_q  <= '0;
            tick_q <= 1'b0;
        end
        else if (div_q == TICK_LAST)
        begin
            div_q  <= '0;
            tick_q <= 1'b1;
        end
        else
        begin
            div_q  <= div_q + 28'h0000001;
            tick_q <= 1'b0;
        end
    end

    // =====================================================================
    // cancel pin synchronisers
    // =====================================================================
    // bit 1 is the settled copy
    logic [1:0] key_sync_q;
    logic [1:0] evt_sync_q;
    logic       cancel;

    // two flops per pin before any logic reads them
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            key_sync_q <= 2'h0;
            evt_sync_q <= 2'h0;
        end
        else
        begin
            key_sync_q <= {key_sync_q[0], latch_cancel_key_pin};
            evt_sync_q <= {evt_sync_q[0], latch_cancel_event_pin};
        end
    end

    // either pin cancels while it stands
    // current over trip sets it again
    assign cancel = key_sync_q[1] | evt_sync_q[1];

    // =====================================================================
    // alarm delay stages
    // =====================================================================
    // delayed states before the relays
    logic [2:0] dly_out;

    // one delay stage per alarm, loop break is ORed into alarm 1 at the relay
    for (genvar i = 0; i < 3; i++)
    begin : g_dly
        aoc_delay u_dly (
            .clk     (clk),
            .rst     (rst),
            .tick    (tick_q),
            .dly_en  (dly_ok(alarm_cfg[i])),
            .cond    (alarm_cond[i]),
            .on_dly  (alarm_cfg[i].on_dly),
            .off_dly (alarm_cfg[i].off_dly),
            .out_q   (dly_out[i])
        );
    end

    // =====================================================================
    // heater-short alarm
    // =====================================================================
    // mode decode and release point
    logic             hs_latched_mode;
    logic             hs_hyst_mode;
    logic             hs_over;
    logic             hs_under;
    logic [AMP_W:0]   hs_release;

    assign hs_latched_mode = hs_cfg.use_flag && hs_cfg.latch_flag;
    assign hs_hyst_mode    = hs_cfg.use_flag && !hs_cfg.latch_flag;
    assign hs_over         = heater_current >= hs_cfg.trip;
    // release point sits one hysteresis band below the trip current
    // a band above trip borrows out,
    // so any current under trip releases
    assign hs_release      = hs_hyst_mode ? ({1'b0, hs_cfg.trip} - {1'b0, hs_cfg.hyst})
                                          : {1'b0, hs_cfg.trip};
    assign hs_under        = hs_release[AMP_W] || {1'b0, heater_current} < hs_release;

    // heater-short state, set wins over hysteresis release
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            heater_short_q <= 1'b0;  // power cycle clears the latch
        end
        else if (!hs_cfg.use_flag)
        begin
            heater_short_q <= 1'b0;
        end
        else if (hs_latched_mode)
        begin
            if (setting_level)
            begin
                heater_short_q <= 1'b0;
            end
            else if (hs_cfg.trip == HS_TRIP_OFF || cancel)
            begin
                heater_short_q <= 1'b0;
            end
            else if (hs_over)
            begin
                heater_short_q <= 1'b1;
            end
        end
        else if (hs_over)
        begin
            heater_short_q <= 1'b1;
        end
        else if (hs_under)
        begin
            heater_short_q <= 1'b0;
        end
    end

    // =====================================================================
    // loop break detection
    // =====================================================================
    // interval, enable and verdict terms
    // runs only with alarm 1 on loop break
    logic [LBA_T_W-1:0] lba_ivl;
    logic               lba_en;
    logic [LBA_T_W-1:0] lba_cnt_q;
    logic [DEV_W-1:0]   lba_start_q;
    logic [DEV_W-1:0]   dev_mag;
    logic               lba_end;
    logic               lba_trip;

    assign lba_ivl = lba_cfg.onoff_ctrl ? lba_cfg.adv_interval
                                        : lba_cfg.pid_interval;
    assign lba_en  = alarm_cfg[0].assigned && alarm_cfg[0].kind == TYPE_LBA
                     && lba_ivl != '0
                     && (lba_cfg.onoff_ctrl || lba_cfg.pid_all_nonzero);
    assign dev_mag = mag(deviation);
    assign lba_end = tick_q && lba_cnt_q + 14'h0001 >= lba_ivl;
    // over level, and reduced by less than the band over the interval
    assign lba_trip = dev_mag > lba_cfg.level
                      && {1'b0, lba_start_q} < {1'b0, dev_mag} + {1'b0, lba_cfg.band};

    // first interval starts from zero,
    // so it reports a break whenever deviation is over level
    // interval timer and start-of-interval sample
    always_ff @(posedge clk)
    begin
        if (rst || !lba_en)
        begin
            lba_cnt_q   <= '0;
            lba_start_q <= '0;
        end
        else if (lba_end)
        begin
            lba_cnt_q   <= '0;
            lba_start_q <= dev_mag;
        end
        else if (tick_q)
        begin
            lba_cnt_q <= lba_cnt_q + 14'h0001;
        end
    end

    // loop break verdict, updated once per interval
    always_ff @(posedge clk)
    begin
        if (rst || !lba_en)
        begin
            loop_break_alarm_q <= 1'b0;
        end
        else if (lba_end)
        begin
            loop_break_alarm_q <= lba_trip;
        end
    end

    // =====================================================================
    // output relays
    // =====================================================================
    // relay drives, one flop each
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            alarm_one_out_q   <= 1'b0;
            alarm_two_out_q   <= 1'b0;
            alarm_three_out_q <= 1'b0;
        end
        else
        begin
            alarm_one_out_q   <= dly_out[0] | loop_break_alarm_q
                                 | (heater_short_q & hs_cfg.use_flag)
                                 | overcurrent_alarm | input_error;
            alarm_two_out_q   <= dly_out[1];
            alarm_three_out_q <= dly_out[2];
        end
    end

    // =====================================================================
    // checks
    // =====================================================================
    // checks are off while reset stands
    AST_HS_USE: assert property (@(posedge clk) disable iff (rst)
        !hs_cfg.use_flag |=> !heater_short_q)
        else $error("heater short raised while unused");

    AST_HS_HOLD: assert property (@(posedge clk) disable iff (rst)
        (heater_short_q && hs_latched_mode && !setting_level && !cancel
         && hs_cfg.trip != HS_TRIP_OFF) |=> heater_short_q)
        else $error("latched heater short dropped");

    AST_HS_LEVEL: assert property (@(posedge clk) disable iff (rst)
        (hs_latched_mode && setting_level) |=> !heater_short_q)
        else $error("latched heater short not forced off");

    AST_HS_HYST: assert property (@(posedge clk) disable iff (rst)
        (heater_short_q && hs_hyst_mode && !hs_under) |=> heater_short_q)
        else $error("heater short released inside hysteresis band");

    AST_LBA_OFF: assert property (@(posedge clk) disable iff (rst)
        !lba_en |=> !loop_break_alarm_q)
        else $error("loop break raised while disabled");

    AST_LBA_STEP: assert property (@(posedge clk) disable iff (rst)
        (lba_en && !lba_end) |=> $stable(loop_break_alarm_q))
        else $error("loop break changed outside interval end");

    AST_LBA_SET: assert property (@(posedge clk) disable iff (rst)
        (lba_en && lba_end && lba_trip) |=> loop_break_alarm_q)
        else $error("loop break not declared");

    AST_A1_OR: assert property (@(posedge clk) disable iff (rst)
        (input_error || overcurrent_alarm) |=> alarm_one_out_q)
        else $error("alarm 1 output missed a merged source");

    // latched clears and merged drive
    AST_SHORT_CANCEL: assert property (@(posedge clk) disable iff (rst)
        (hs_latched_mode && cancel) |=> !heater_short_q)
        else $error("latch cancel ignored");

    AST_SHORT_TRIP_OFF: assert property (@(posedge clk) disable iff (rst)
        (hs_latched_mode && hs_cfg.trip == HS_TRIP_OFF) |=> !heater_short_q)
        else $error("latch held at trip off setting");

    AST_A1_SHORT: assert property (@(posedge clk) disable iff (rst)
        (heater_short_q && hs_cfg.use_flag) |=> alarm_one_out_q)
        else $error("heater short missing on alarm 1");

    // unlatched set and loop break release
    AST_SHORT_SET: assert property (@(posedge clk) disable iff (rst)
        (hs_hyst_mode && hs_over) |=> heater_short_q)
        else $error("heater short not raised");

    AST_BREAK_CLR: assert property (@(posedge clk) disable iff (rst)
        (lba_en && lba_end && !lba_trip) |=> !loop_break_alarm_q)
        else $error("loop break not cleared");

endmodule : aoc_top

// ---- tb/aoc_plant.sv ----
/*
 * process measurement stand-in: presents heater current and deviation.
 * assumes requests change at the falling edge; outputs move on the rising edge.
 */
`timescale 1ns/1ps
module aoc_plant
    import aoc_pkg::*;
(
    input  wire logic             clk,
    input  wire logic [AMP_W-1:0] heat_req,
    input  wire logic [DEV_W-1:0] dev_req,
    output logic      [AMP_W-1:0] heater_current,
    output logic      [DEV_W-1:0] deviation
);
    // =====================================================================
    // measurement
    // =====================================================================
    // one cycle of conversion latency, like a sampled sensor front end
    always_ff @(posedge clk)
    begin
        heater_current <= heat_req;
        deviation      <= dev_req;
    end
endmodule : aoc_plant

// ---- tb/aoc_top_tb.sv ----
/*
 * bench for aoc_top: queue-checked delays, heater short and loop break.
 * assumes aoc_plant supplies measurements and a tick divider of 10 cycles.
 */
`timescale 1ns/1ps
module aoc_top_tb
    import aoc_pkg::*;
();
    // =====================================================================
    // signals
    // =====================================================================
    localparam int TB_DIV = 10;
    typedef struct packed {logic [2:0] id; logic e;} aoc_note_t;
    logic                 clk;
    logic                 rst;
    aoc_alarm_cfg_t [2:0] alarm_cfg;
    logic [2:0]           alarm_cond;
    aoc_hs_cfg_t          hs_cfg;
    aoc_lba_cfg_t         lba_cfg;
    logic [AMP_W-1:0]     heat_req;
    logic [AMP_W-1:0]     heater_current;
    logic [DEV_W-1:0]     dev_req;
    logic [DEV_W-1:0]     deviation;
    logic                 overcurrent_alarm;
    logic                 input_error;
    logic                 setting_level;
    logic                 key_pin;
    logic                 event_pin;
    wire [4:0]            obs;
    logic [31:0]          cyc_cnt;
    logic [31:0]          rnd;
    logic [4:0]           codes [4] = '{5'h00, 5'h0c, 5'h0d, 5'h02};
    int                   num_errors = 0;
    int                   cmp_count = 0;
    int                   seed = 52;
    aoc_note_t            note_q [$];

    // =====================================================================
    // instances
    // =====================================================================
    aoc_top #(.TICK_DIV(TB_DIV)) dut_u (
        .clk(clk), .rst(rst), .alarm_cfg(alarm_cfg), .alarm_cond(alarm_cond),
        .hs_cfg(hs_cfg), .heater_current(heater_current),
        .overcurrent_alarm(overcurrent_alarm), .input_error(input_error),
        .setting_level(setting_level), .latch_cancel_key_pin(key_pin),
        .latch_cancel_event_pin(event_pin), .lba_cfg(lba_cfg), .deviation(deviation),
        .alarm_one_out_q(obs[0]), .alarm_two_out_q(obs[1]), .alarm_three_out_q(obs[2]),
        .heater_short_q(obs[3]), .loop_break_alarm_q(obs[4]));
    aoc_plant plant_u (.clk(clk), .heat_req(heat_req), .dev_req(dev_req),
        .heater_current(heater_current), .deviation(deviation));

    // =====================================================================
    // clock, tick phase and checking
    // =====================================================================
    // 200 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // cycles since reset release, to find the tick phase
    always_ff @(posedge clk)
        if (rst) cyc_cnt <= '0;
        else cyc_cnt <= cyc_cnt + 32'h1;
    // takes each note once outputs have settled after the falling edge
    always @(negedge clk)
    begin
        aoc_note_t n;
        #1;
        while (note_q.size() > 0)
        begin
            n = note_q.pop_front();
            cmp_count++;
            if (obs[n.id] !== n.e)
            begin
                num_errors++;
                $display("CHECK FAILED out%0d expected %b seen %b", n.id, n.e, obs[n.id]);
            end
        end
    end
    // hang guard, far beyond the roughly 450 cycles of the run
    initial
    begin
        repeat (20000) @(negedge clk);
        num_errors++;
        test_done();
    end

    // =====================================================================
    // tasks
    // =====================================================================
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc
    task automatic expect_bit(input logic [2:0] id, input logic e);
        note_q.push_back('{id, e});
    endtask : expect_bit
    // moves to the middle of a tick interval
    task automatic align();
        do cyc(1); while (cyc_cnt % 32'(TB_DIV) != 32'h5);
    endtask : align
    // raises and leaves a latched heater short
    task automatic hs_set();
        heat_req = 10'h078;
        cyc(4);
        heat_req = 10'h000;
        cyc(4);
    endtask : hs_set
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : test_done

    // =====================================================================
    // scenarios
    // =====================================================================
    initial
    begin
        rst = 1'b1;
        alarm_cfg = '0;
        alarm_cond = '0;
        hs_cfg = '{1'b0, 1'b0, 10'h064, 10'h00a};
        lba_cfg = '0;
        heat_req = '0;
        dev_req = '0;
        overcurrent_alarm = 1'b0;
        input_error = 1'b0;
        setting_level = 1'b0;
        key_pin = 1'b0;
        event_pin = 1'b0;
        cyc(20);
        rst = 1'b0;
        cyc(3);
        for (int i = 0; i < 5; i++) expect_bit(3'(i), 1'b0);
        // ineligible codes and unassigned alarm pass at once
        foreach (codes[k])
        begin
            alarm_cfg[1] = '{codes[k] != 5'h02, codes[k], 10'h005, 10'h005};
            alarm_cond[1] = 1'b1;
            cyc(2);
            expect_bit(3'h1, 1'b1);
            alarm_cond[1] = 1'b0;
            cyc(2);
            expect_bit(3'h1, 1'b0);
        end
        alarm_cfg[2] = '{1'b1, 5'h02, 10'h000, 10'h000};
        repeat (20)
        begin
            rnd = $random(seed);
            alarm_cond[2] = rnd[0];
            cyc(2);
            expect_bit(3'h2, rnd[0]);
        end
        $display("test zero delays done");
        alarm_cfg[1] = '{1'b1, 5'h02, 10'h003, 10'h002};
        alarm_cond[1] = 1'b1;
        cyc(19);
        expect_bit(3'h1, 1'b0);
        cyc(23);
        expect_bit(3'h1, 1'b1);
        alarm_cond[1] = 1'b0;
        cyc(9);
        expect_bit(3'h1, 1'b1);
        cyc(25);
        expect_bit(3'h1, 1'b0);
        alarm_cond[1] = 1'b1;
        cyc(15);
        alarm_cond[1] = 1'b0;
        cyc(2);
        alarm_cond[1] = 1'b1;
        cyc(19);
        expect_bit(3'h1, 1'b0);
        cyc(23);
        expect_bit(3'h1, 1'b1);
        $display("test timed delays done");
        alarm_cfg[0] = '{1'b1, 5'h02, 10'h000, 10'h000};
        hs_cfg.use_flag = 1'b1;
        heat_req = 10'h078;
        cyc(4);
        expect_bit(3'h3, 1'b1);
        expect_bit(3'h0, 1'b1);
        heat_req = 10'h05f;
        cyc(4);
        expect_bit(3'h3, 1'b1);
        heat_req = 10'h059;
        cyc(4);
        expect_bit(3'h3, 1'b0);
        heat_req = 10'h078;
        hs_cfg.use_flag = 1'b0;
        cyc(4);
        expect_bit(3'h3, 1'b0);
        expect_bit(3'h0, 1'b0);
        hs_cfg = '{1'b1, 1'b1, 10'h064, 10'h00a};
        for (int p = 0; p < 2; p++)
        begin
            hs_set();
            expect_bit(3'h3, 1'b1);
            if (p == 0) key_pin = 1'b1;
            else event_pin = 1'b1;
            cyc(4);
            key_pin = 1'b0;
            event_pin = 1'b0;
            cyc(3);
            expect_bit(3'h3, 1'b0);
        end
        hs_set();
        hs_cfg.trip = HS_TRIP_OFF;
        cyc(4);
        expect_bit(3'h3, 1'b0);
        hs_cfg.trip = 10'h064;
        hs_set();
        setting_level = 1'b1;
        cyc(4);
        expect_bit(3'h3, 1'b0);
        setting_level = 1'b0;
        hs_cfg.use_flag = 1'b0;
        cyc(2);
        for (int s = 0; s < 3; s++)
        begin
            overcurrent_alarm = (s == 0);
            input_error = (s == 1);
            alarm_cond[0] = (s == 2);
            cyc(2);
            expect_bit(3'h0, 1'b1);
        end
        input_error = 1'b0;
        alarm_cond[0] = 1'b0;
        cyc(2);
        expect_bit(3'h0, 1'b0);
        $display("test heater short done");
        alarm_cfg[0] = '{1'b1, TYPE_LBA, 10'h000, 10'h000};
        lba_cfg = '{14'h0001, 14'h0000, 1'b0, 1'b1, 16'h0050, 16'h000a};
        rnd = $random(seed);
        dev_req = 16'h0080 + {8'h00, rnd[7:0]};
        cyc(15);
        expect_bit(3'h4, 1'b1);
        expect_bit(3'h0, 1'b1);
        align();
        dev_req = dev_req - 16'h0020;
        cyc(10);
        expect_bit(3'h4, 1'b0);
        cyc(10);
        expect_bit(3'h4, 1'b1);
        dev_req = 16'h0040;
        cyc(20);
        expect_bit(3'h4, 1'b0);
        dev_req = 16'hff38;
        cyc(10);
        expect_bit(3'h4, 1'b1);
        lba_cfg.adv_interval = 14'h0000;
        cyc(4);
        expect_bit(3'h4, 1'b0);
        lba_cfg.onoff_ctrl = 1'b0;
        lba_cfg.pid_interval = 14'h0001;
        lba_cfg.pid_all_nonzero = 1'b1;
        cyc(25);
        expect_bit(3'h4, 1'b1);
        lba_cfg.pid_all_nonzero = 1'b0;
        cyc(4);
        expect_bit(3'h4, 1'b0);
        lba_cfg.pid_all_nonzero = 1'b1;
        cyc(25);
        alarm_cfg[0].kind = 5'h02;
        cyc(4);
        expect_bit(3'h4, 1'b0);
        expect_bit(3'h0, 1'b0);
        $display("test loop break done");
        cyc(3);
        test_done();
    end
endmodule : aoc_top_tb
